// ### hw/stap_top.sv
// Boundary-scan test access port of the signal processor
// How it works
// [R1] Mode select is sampled into the controller on each test clock rising edge.
// [R2] Serial data in shifts into the selected instruction or data register on rising edges.
// [R3] Serial data out changes only on test clock falling edges.
// [R4] Serial data out floats except while a shift state is scanning out.
// [R5] Serial data out floats while the global output-disable is active.
// [R6] Test reset high gives scan control; low ignores all scan inputs.
// [R7] Output-disable latches on test reset fall with line a high; line b low floats.
// [R8] Controller follows the standard state sequence; forced to reset while test reset low.
`timescale 1ns/1ps
`default_nettype none
module stap_top #(
  parameter int unsigned USER_W = stap_pkg::USER_WIDTH
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // Scan pins
  input  wire logic                   tck_i,
  input  wire logic                   tms_i,
  input  wire logic                   tdi_i,
  input  wire logic                   trst_n_i,
  output logic                        tdo_o,
  output logic                        tdo_oe_n_o,
  // Emulator lines
  input  wire logic                   emulator_event_line_a_i,
  input  wire logic                   emulator_event_line_b_i,
  // Device side
  output logic                        scan_control_o,
  output logic                        outputs_off_o,
  output logic [USER_W-1:0]           user_data_o,
  output logic [stap_pkg::IR_WIDTH-1:0] instr_o
);

  // ==========================================================
  // Parameter check
  // Shift paths slice [USER_W-1:1], so one bit cannot be served
  if (USER_W < 2) begin : gen_user_w_check
    $error("USER_W must be at least 2 for the shift path");
  end

  stap_sync_if sync ();

  stap_pin_sync u_sync (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .tck_i    (tck_i),
    .tms_i    (tms_i),
    .tdi_i    (tdi_i),
    .trst_n_i (trst_n_i),
    .emu_a_i  (emulator_event_line_a_i),
    .emu_b_i  (emulator_event_line_b_i),
    .sync     (sync)
  );

  stap_pkg::stap_state_e       state_reg;
  stap_pkg::stap_state_e       state_next;
  logic [stap_pkg::IR_WIDTH-1:0] ir_shift_reg;
  logic [stap_pkg::IR_WIDTH-1:0] ir_reg;
  logic [stap_pkg::ID_WIDTH-1:0] id_shift_reg;
  logic [USER_W-1:0]           user_shift_reg;
  logic [USER_W-1:0]           user_reg;
  logic                        bypass_reg;
  logic                        tdo_reg;
  logic                        tdo_en_reg;
  logic                        trst_last_reg;
  logic                        off_armed_reg;
  logic                        serial_bit;

  // ==========================================================
  // Next state of the standard controller
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      stap_pkg::ST_TEST_LOGIC_RESET:
        state_next = sync.tms ? stap_pkg::ST_TEST_LOGIC_RESET : stap_pkg::ST_RUN_IDLE;
      stap_pkg::ST_RUN_IDLE:
        state_next = sync.tms ? stap_pkg::ST_SELECT_DR : stap_pkg::ST_RUN_IDLE;
      stap_pkg::ST_SELECT_DR:
        state_next = sync.tms ? stap_pkg::ST_SELECT_IR : stap_pkg::ST_CAPTURE_DR;
      stap_pkg::ST_CAPTURE_DR:
        state_next = sync.tms ? stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
      stap_pkg::ST_SHIFT_DR:
        state_next = sync.tms ? stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
      stap_pkg::ST_EXIT1_DR:
        state_next = sync.tms ? stap_pkg::ST_UPDATE_DR : stap_pkg::ST_PAUSE_DR;
      stap_pkg::ST_PAUSE_DR:
        state_next = sync.tms ? stap_pkg::ST_EXIT2_DR : stap_pkg::ST_PAUSE_DR;
      stap_pkg::ST_EXIT2_DR:
        state_next = sync.tms ? stap_pkg::ST_UPDATE_DR : stap_pkg::ST_SHIFT_DR;
      stap_pkg::ST_UPDATE_DR:
        state_next = sync.tms ? stap_pkg::ST_SELECT_DR : stap_pkg::ST_RUN_IDLE;
      stap_pkg::ST_SELECT_IR:
        state_next = sync.tms ? stap_pkg::ST_TEST_LOGIC_RESET : stap_pkg::ST_CAPTURE_IR;
      stap_pkg::ST_CAPTURE_IR:
        state_next = sync.tms ? stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
      stap_pkg::ST_SHIFT_IR:
        state_next = sync.tms ? stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
      stap_pkg::ST_EXIT1_IR:
        state_next = sync.tms ? stap_pkg::ST_UPDATE_IR : stap_pkg::ST_PAUSE_IR;
      stap_pkg::ST_PAUSE_IR:
        state_next = sync.tms ? stap_pkg::ST_EXIT2_IR : stap_pkg::ST_PAUSE_IR;
      stap_pkg::ST_EXIT2_IR:
        state_next = sync.tms ? stap_pkg::ST_UPDATE_IR : stap_pkg::ST_SHIFT_IR;
      stap_pkg::ST_UPDATE_IR:
        state_next = sync.tms ? stap_pkg::ST_SELECT_DR : stap_pkg::ST_RUN_IDLE;
      default:
        state_next = stap_pkg::ST_TEST_LOGIC_RESET;
    endcase
  end

  // State register, held in reset while test reset is low
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= stap_pkg::ST_TEST_LOGIC_RESET;
    end else if (!sync.trst_n) begin
      state_reg <= stap_pkg::ST_TEST_LOGIC_RESET;          // see [R8] see [R6]
    end else if (sync.tck_rise) begin
      state_reg <= state_next;                             // see [R1] see [R8]
    end
  end

  // ==========================================================
  // Instruction register path
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ir_shift_reg <= stap_pkg::IR_RESET_VALUE;
      ir_reg       <= stap_pkg::IR_RESET_VALUE;
    end else if (!sync.trst_n || state_reg == stap_pkg::ST_TEST_LOGIC_RESET) begin
      ir_shift_reg <= stap_pkg::IR_RESET_VALUE;
      ir_reg       <= stap_pkg::IR_RESET_VALUE;            // see [R6]
    end else if (sync.tck_rise) begin
      if (state_reg == stap_pkg::ST_CAPTURE_IR) begin
        ir_shift_reg <= stap_pkg::IR_CAPTURE_VALUE;
      end else if (state_reg == stap_pkg::ST_SHIFT_IR) begin
        ir_shift_reg <= {sync.tdi, ir_shift_reg[stap_pkg::IR_WIDTH-1:1]}; // see [R2]
      end else if (state_reg == stap_pkg::ST_UPDATE_IR) begin
        ir_reg <= ir_shift_reg;
      end
    end
  end

  // Data registers: capture of all three, shift of the selected one, update of the user one
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      id_shift_reg   <= stap_pkg::ID_VALUE;
      user_shift_reg <= USER_W'(stap_pkg::USER_RESET_VALUE);
      user_reg       <= USER_W'(stap_pkg::USER_RESET_VALUE);
      bypass_reg     <= 1'b0;
    end else if (!sync.trst_n) begin
      user_reg       <= USER_W'(stap_pkg::USER_RESET_VALUE);
    end else if (sync.tck_rise) begin
      if (state_reg == stap_pkg::ST_CAPTURE_DR) begin
        id_shift_reg   <= stap_pkg::ID_VALUE;
        user_shift_reg <= user_reg;
        bypass_reg     <= 1'b0;
      end else if (state_reg == stap_pkg::ST_SHIFT_DR) begin
        if (ir_reg == stap_pkg::INSTR_IDCODE) begin
          id_shift_reg <= {sync.tdi, id_shift_reg[stap_pkg::ID_WIDTH-1:1]}; // see [R2]
        end else if (ir_reg == stap_pkg::INSTR_USER) begin
          user_shift_reg <= {sync.tdi, user_shift_reg[USER_W-1:1]};        // see [R2]
        end else begin
          bypass_reg <= sync.tdi;                                          // see [R2]
        end
      end else if (state_reg == stap_pkg::ST_UPDATE_DR && ir_reg == stap_pkg::INSTR_USER) begin
        user_reg <= user_shift_reg;
      end
    end
  end

  // ==========================================================
  // Bit presented at the serial output
  always_comb begin
    if (state_reg == stap_pkg::ST_SHIFT_IR) begin
      serial_bit = ir_shift_reg[0];
    end else if (ir_reg == stap_pkg::INSTR_IDCODE) begin
      serial_bit = id_shift_reg[0];
    end else if (ir_reg == stap_pkg::INSTR_USER) begin
      serial_bit = user_shift_reg[0];
    end else begin
      serial_bit = bypass_reg;
    end
  end

  // Output data changes on falling edges only; enable also clears while test reset is low
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tdo_reg    <= 1'b0;
      tdo_en_reg <= 1'b0;
    end else if (!sync.trst_n) begin
      tdo_en_reg <= 1'b0;                                  // see [R6] see [R4]
    end else if (sync.tck_fall) begin
      tdo_reg    <= serial_bit;                            // see [R3]
      tdo_en_reg <= (state_reg == stap_pkg::ST_SHIFT_DR) ||
                    (state_reg == stap_pkg::ST_SHIFT_IR);  // see [R4]
    end
  end

  // ==========================================================
  // Output-disable arming on the falling edge of test reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      trst_last_reg <= 1'b0;
      off_armed_reg <= 1'b0;
    end else begin
      trst_last_reg <= sync.trst_n;
      if (sync.trst_n) begin
        off_armed_reg <= 1'b0;
      end else if (trst_last_reg && sync.emu_a) begin
        off_armed_reg <= 1'b1;                             // see [R7]
      end
    end
  end

  // Pin drive and device-side status
  assign outputs_off_o  = off_armed_reg & ~sync.emu_b;     // see [R7]
  assign tdo_o          = tdo_reg;
  assign tdo_oe_n_o     = ~(tdo_en_reg & ~outputs_off_o);  // see [R5] see [R4]
  assign scan_control_o = sync.trst_n;                     // see [R6]
  assign user_data_o    = user_reg;
  assign instr_o        = ir_reg;

endmodule : stap_top
`default_nettype wire

// ### hw/stap_pkg.sv
// Constants and types shared by the scan test access port
package stap_pkg;

  // ==========================================================
  // Instruction register
  localparam int unsigned IR_WIDTH = 4;
  localparam logic [3:0] IR_RESET_VALUE = 4'h1;    // Idcode-style default after reset
  localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;  // Fixed pattern captured in capture-ir
  localparam logic [3:0] INSTR_BYPASS = 4'hF;
  localparam logic [3:0] INSTR_IDCODE = 4'h1;
  localparam logic [3:0] INSTR_USER = 4'h2;

  // ==========================================================
  // Data registers
  localparam int unsigned ID_WIDTH = 32;
  localparam int unsigned USER_WIDTH = 16;
  localparam logic [31:0] ID_VALUE = 32'h0000_1001; // Arbitrary neutral identity value
  localparam logic [15:0] USER_RESET_VALUE = 16'h0000;

  // ==========================================================
  // Standard boundary-scan controller states
  typedef enum logic [3:0] {
    ST_TEST_LOGIC_RESET,
    ST_RUN_IDLE,
    ST_SELECT_DR,
    ST_CAPTURE_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPDATE_DR,
    ST_SELECT_IR,
    ST_CAPTURE_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPDATE_IR
  } stap_state_e;

endpackage : stap_pkg

// ### hw/stap_sync_if.sv
// Synchronised scan pins passed from the pin stage to the core
`timescale 1ns/1ps
`default_nettype none
interface stap_sync_if;
  logic tck_rise;   // One-cycle pulse on a test clock rising edge
  logic tck_fall;   // One-cycle pulse on a test clock falling edge
  logic tms;        // Synchronised mode select
  logic tdi;        // Synchronised serial data in
  logic trst_n;     // Synchronised test reset, active low
  logic emu_a;      // Synchronised emulator line a
  logic emu_b;      // Synchronised emulator line b
  modport pins (output tck_rise, tck_fall, tms, tdi, trst_n, emu_a, emu_b);
  modport core (input tck_rise, tck_fall, tms, tdi, trst_n, emu_a, emu_b);
endinterface : stap_sync_if
`default_nettype wire

// ### hw/stap_pin_sync.sv
// Two-stage synchronisers and test clock edge detection
`timescale 1ns/1ps
`default_nettype none
module stap_pin_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Raw pins
  input  wire logic tck_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  input  wire logic trst_n_i,
  input  wire logic emu_a_i,
  input  wire logic emu_b_i,
  // Synchronised side
  stap_sync_if.pins sync
);

  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic       tck_last_reg;

  // ==========================================================
  // Two flip-flops per pin; only sync_reg is read onward
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= 6'h00;
      sync_reg <= 6'h00;
    end else begin
      meta_reg <= {emu_b_i, emu_a_i, trst_n_i, tdi_i, tms_i, tck_i};
      sync_reg <= meta_reg;
    end
  end

  // Previous test clock level for edge finding
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tck_last_reg <= 1'b0;
    end else begin
      tck_last_reg <= sync_reg[0];
    end
  end

  // Edge pulses and level outputs
  assign sync.tck_rise = sync_reg[0] & ~tck_last_reg;
  assign sync.tck_fall = ~sync_reg[0] & tck_last_reg;
  assign sync.tms      = sync_reg[1];
  assign sync.tdi      = sync_reg[2];
  assign sync.trst_n   = sync_reg[3];
  assign sync.emu_a    = sync_reg[4];
  assign sync.emu_b    = sync_reg[5];

endmodule : stap_pin_sync
`default_nettype wire

// ### tb/stap_properties.sv
// Checker of the scan port timing and float rules
`timescale 1ns/1ps
`default_nettype none
module stap_properties #(
  parameter int unsigned USER_W = 16
) (
  // Watched top ports
  input wire logic                          clk_i,
  input wire logic                          reset_i,
  input wire logic                          tck_i,
  input wire logic                          tms_i,
  input wire logic                          tdi_i,
  input wire logic                          trst_n_i,
  input wire logic                          tdo_o,
  input wire logic                          tdo_oe_n_o,
  input wire logic                          emulator_event_line_a_i,
  input wire logic                          emulator_event_line_b_i,
  input wire logic                          scan_control_o,
  input wire logic                          outputs_off_o,
  input wire logic [USER_W-1:0]             user_data_o,
  input wire logic [stap_pkg::IR_WIDTH-1:0] instr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================
  // Output-disable arming
  sequence off_armed_s;
    $fell(trst_n_i) && emulator_event_line_a_i ##1
      (!trst_n_i && emulator_event_line_a_i && !emulator_event_line_b_i)[*6];
  endsequence
  chk_off_arm: assert property (off_armed_s |-> outputs_off_o)
    else $error("output-disable not active");
  chk_off_idle: assert property (trst_n_i[*6] |-> !outputs_off_o)
    else $error("output-disable active with test reset high");
  chk_off_float: assert property (outputs_off_o |-> tdo_oe_n_o)
    else $error("tdo driven under output-disable");
  // ==========================================================
  // Scan ownership and edge timing
  chk_trst_float: assert property ((!trst_n_i)[*6] |-> tdo_oe_n_o && !scan_control_o)
    else $error("scan active while test reset low");
  chk_scan_on: assert property ($rose(trst_n_i) |-> ##[1:5] scan_control_o)
    else $error("scan control not taken");
  chk_tdo_fall: assert property ($changed(tdo_o) |-> !$past(tck_i, 2))
    else $error("tdo changed away from a falling edge");
  chk_oe_fall: assert property ($fell(tdo_oe_n_o) |-> !$past(tck_i, 2))
    else $error("tdo enabled away from a falling edge");
  chk_instr_rise: assert property ($changed(instr_o) |-> $past(tck_i, 2) || !$past(trst_n_i, 2))
    else $error("instruction changed without a rising edge");
endmodule : stap_properties
bind stap_top stap_properties #(.USER_W(USER_W)) stap_properties_i (
  .clk_i(clk_i), .reset_i(reset_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
  .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
  .emulator_event_line_a_i(emulator_event_line_a_i),
  .emulator_event_line_b_i(emulator_event_line_b_i), .scan_control_o(scan_control_o),
  .outputs_off_o(outputs_off_o), .user_data_o(user_data_o), .instr_o(instr_o));
`default_nettype wire

// ### tb/stap_scan_ctrl.sv
// Behavioural scan controller driving the test clock and serial pins
`timescale 1ns/1ps
`default_nettype none
module stap_scan_ctrl (
  // Scan pins
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_n_i
);
  logic tdo_seen;
  // Released data out has no pull, so it reads as floating
  assign tdo_seen = tdo_oe_n_i ? 1'bZ : tdo_i;
  // Clock still outside frames; pulled-up pins high at the start of the run
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // One clock period: pins set while low, data out read after the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #200 tck_o = 1'b1;
    #100 tdo = tdo_seen;
    #100 tck_o = 1'b0;
  endtask : step
endmodule : stap_scan_ctrl
`default_nettype wire

// ### tb/stap_top_tb_top.sv
// Self-checking bench for the scan test access port
`timescale 1ns/1ps
`default_nettype none
module stap_top_tb_top;
  logic                          clk_i, reset_i, tck, tms, tdi, trst_n, tdo, oe_n;
  logic                          emu_a, emu_b, scan_ctl, off;
  logic [15:0]                   user_data;
  logic [stap_pkg::IR_WIDTH-1:0] instr;
  int                            miscompares = 0, compares = 0, cycles = 0;
  logic [31:0]                   d;
  // ==========================================================
  // Design and far-side controller
  stap_top #(.USER_W(16)) stap_top_i (.clk_i(clk_i), .reset_i(reset_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_n_o(oe_n),
    .emulator_event_line_a_i(emu_a), .emulator_event_line_b_i(emu_b),
    .scan_control_o(scan_ctl), .outputs_off_o(off), .user_data_o(user_data), .instr_o(instr));
  stap_scan_ctrl stap_scan_ctrl_i (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
    .tdo_oe_n_i(oe_n));
  // Clock generation
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Cycle ceiling against hangs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // Test reset and emulator lines set at the falling edge, then settle
  task automatic pins(input logic t, input logic a, input logic b);
    @(negedge clk_i);
    trst_n = t;
    emu_a = a;
    emu_b = b;
    repeat (8) @(negedge clk_i);
  endtask : pins
  // Run-idle through one register scan back to run-idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din);
    logic b;
    d = '0;
    stap_scan_ctrl_i.step(1'b1, 1'b1, b);
    if (ir) stap_scan_ctrl_i.step(1'b1, 1'b1, b);
    stap_scan_ctrl_i.step(1'b0, 1'b1, b);
    stap_scan_ctrl_i.step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      stap_scan_ctrl_i.step(i == n - 1, din[i], b);
      d[i] = b;
    end
    stap_scan_ctrl_i.step(1'b1, 1'b1, b);
    stap_scan_ctrl_i.step(1'b0, 1'b1, b);
  endtask : scan
  // ==========================================================
  // Scenarios
  task automatic test_idcode();
    logic b;
    pins(1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 6; i++) stap_scan_ctrl_i.step(i < 5, 1'b1, b);
    check(scan_ctl, 1'b1, "scan control");
    scan(1'b0, 32, 32'h0);
    check(d, stap_pkg::ID_VALUE, "identity shift");
    check(oe_n, 1'b1, "float in idle");
    $display("test_idcode done");
  endtask : test_idcode
  task automatic test_user();
    scan(1'b1, 4, stap_pkg::INSTR_USER);
    check(d, stap_pkg::IR_CAPTURE_VALUE, "ir capture");
    check(instr, stap_pkg::INSTR_USER, "user instr");
    scan(1'b0, 16, 32'h0000_A5C3);
    check(user_data, 16'hA5C3, "user data");
    scan(1'b1, 4, stap_pkg::INSTR_BYPASS);
    scan(1'b0, 8, 32'h0000_00B6);
    check(d, 32'h0000_006C, "bypass delay");
    $display("test_user done");
  endtask : test_user
  // User scan split by a pause; data out must float while paused
  task automatic test_pause();
    logic        b;
    logic [15:0] v;
    v = 16'h3C5A;
    scan(1'b1, 4, stap_pkg::INSTR_USER);
    stap_scan_ctrl_i.step(1'b1, 1'b1, b);
    stap_scan_ctrl_i.step(1'b0, 1'b1, b);
    stap_scan_ctrl_i.step(1'b0, 1'b1, b);
    d = '0;
    for (int i = 0; i < 16; i++) begin
      stap_scan_ctrl_i.step(i == 7 || i == 15, v[i], b);
      d[i] = b;
      if (i == 7) begin
        // Exit to pause, wait one step there, then back to shift
        stap_scan_ctrl_i.step(1'b0, 1'b1, b);
        stap_scan_ctrl_i.step(1'b1, 1'b1, b);
        check(b, 1'bZ, "float in pause");
        stap_scan_ctrl_i.step(1'b0, 1'b1, b);
      end
    end
    stap_scan_ctrl_i.step(1'b1, 1'b1, b);
    stap_scan_ctrl_i.step(1'b0, 1'b1, b);
    check(d, 32'h0000_A5C3, "user capture");
    check(user_data, 16'h3C5A, "paused user data");
    $display("test_pause done");
  endtask : test_pause
  task automatic test_trst();
    pins(1'b0, 1'b1, 1'b0);
    check({off, oe_n}, 2'b11, "output-disable");
    pins(1'b0, 1'b1, 1'b1);
    check(off, 1'b0, "line b high");
    scan(1'b1, 4, stap_pkg::INSTR_USER);
    check(d, {28'h0, 4'hZ}, "float in test reset");
    check({scan_ctl, instr}, {1'b0, stap_pkg::IR_RESET_VALUE}, "scan ignored");
    $display("test_trst done");
  endtask : test_trst
  // Verdict and end of run
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    reset_i = 1'b1;
    trst_n = 1'b0;
    emu_a = 1'b1;
    emu_b = 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check({oe_n, scan_ctl, off, instr, user_data}, {3'b100, stap_pkg::IR_RESET_VALUE,
      stap_pkg::USER_RESET_VALUE}, "reset outputs");
    test_idcode();
    test_user();
    test_pause();
    test_trst();
    summarize();
  end
endmodule : stap_top_tb_top
`default_nettype wire
